// File: src/pod_params.svh
`ifndef POD_PARAMS_SVH
`define POD_PARAMS_SVH
`define POD_IDX_LOCKOUT 14'h30e1
`define POD_IDX_MIN_PULSE 14'h30ea
`define POD_IDX_WINDOW 14'h30eb
`define POD_IDX_CTRL 14'h30f0
`define POD_IDX_IRQ_STATUS 14'h30f1
`define POD_IDX_IRQ_MASK 14'h30f2
`define POD_IDX_PORT_STATE 14'h30f3
`define POD_RST_LOCKOUT 8'h0a
`define POD_RST_MIN_PULSE 4'h5
`define POD_RST_WINDOW 8'h14
`define POD_CTRL_GANG_BIT 8
`define POD_STATE_PIN_LSB 8
`define POD_STATE_SHARED_BIT 16
`define POD_STEP_NS 1000000
`define POD_CLK_NS 20
`endif

// File: src/pod_pkg.sv
package pod_pkg;
  typedef logic [15:0] pod_addr_t;
  typedef logic [31:0] pod_data_t;
  typedef logic [1:0] pod_resp_t;
  typedef struct packed {
    logic [7:0] lockout;
    logic [3:0] min_width;
    logic [7:0] window;
  } pod_cfg_s;
  typedef enum logic [1:0] {
    POD_WR_COLLECT = 2'b01,
    POD_WR_RESP = 2'b10
  } pod_wr_e;
  typedef enum logic [1:0] {
    POD_RD_IDLE = 2'b01,
    POD_RD_RESP = 2'b10
  } pod_rd_e;
endpackage : pod_pkg

// File: src/pod_top.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pod_params.svh"
module pod_top #(
  parameter int N_PORTS = 7,
  parameter int MS_CYCLES = `POD_STEP_NS / `POD_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire pod_pkg::pod_addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire pod_pkg::pod_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output pod_pkg::pod_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire pod_pkg::pod_addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pod_pkg::pod_data_t s_axi_rdata,
  output pod_pkg::pod_resp_t s_axi_rresp,
  input wire logic [N_PORTS-1:0] port_power_sense_pin_i,
  output logic [N_PORTS-1:0] port_power_sense_pin_o,
  output logic [N_PORTS-1:0] port_power_sense_pin_oe_n,
  output logic [N_PORTS-1:0] port_pullup_en,
  input wire logic shared_power_sense_pin_i,
  output logic shared_power_sense_pin_o,
  output logic shared_power_sense_pin_oe_n,
  output logic shared_pullup_en,
  output logic [N_PORTS-1:0] port_overcurrent,
  output logic irq
);
  import pod_pkg::*;

  localparam int NCH = N_PORTS + 1;
  localparam int TW = $clog2(MS_CYCLES + 1);

  pod_cfg_s cfg;
  logic [N_PORTS-1:0] port_en;
  logic gang_mode;
  logic [N_PORTS-1:0] irq_status;
  logic [N_PORTS-1:0] irq_mask;

  // free-running 1 ms step shared by all channels
  // a filter started mid-step may see up to one step less than programmed
  logic [TW-1:0] step_cnt;
  logic step;
  assign step = (step_cnt == TW'(MS_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= '0;
    end else if (step) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + TW'(1);
    end
  end

  // channel N_PORTS is the shared pin used in ganged mode
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_pin;
  logic [NCH-1:0] ch_sync;
  logic [NCH-1:0] ch_oc;
  always_comb begin
    ch_en = {gang_mode & port_en[0], port_en & {N_PORTS{~gang_mode}}};
    ch_pin = {shared_power_sense_pin_i, port_power_sense_pin_i};
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic s1;
    logic s2;
    logic [7:0] lock_cnt;
    logic [3:0] low_ms;
    logic [7:0] win_cnt;
    logic low_prev;
    logic low;
    logic group_start;
    logic single_hit;
    logic double_hit;

    // sense pin is asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1 <= 1'b1;
        s2 <= 1'b1;
      end else begin
        s1 <= ch_pin[g];
        s2 <= s1;
      end
    end
    assign ch_sync[g] = s2;

    // lockout reloads while off so every power-on restarts it
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lock_cnt <= `POD_RST_LOCKOUT;
      end else if (!ch_en[g]) begin
        lock_cnt <= cfg.lockout;
      end else if (step && lock_cnt != 8'h00) begin
        lock_cnt <= lock_cnt - 8'h01;
      end
    end

    // a zero lockout setting would let ramp glitches through
    assign low = ch_en[g] && (lock_cnt == 8'h00) && !s2;
    assign group_start = low && !low_prev;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        low_prev <= 1'b0;
      end else begin
        low_prev <= low;
      end
    end

    // width of the current low run in whole steps, saturating
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        low_ms <= 4'h0;
      end else if (!low) begin
        low_ms <= 4'h0;
      end else if (step && low_ms != 4'hf) begin
        low_ms <= low_ms + 4'h1;
      end
    end
    assign single_hit = low && (low_ms >= cfg.min_width);

    // window opens at the first low group and counts down in steps
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        win_cnt <= 8'h00;
      end else if (!ch_en[g]) begin
        win_cnt <= 8'h00;
      end else if (group_start && win_cnt == 8'h00) begin
        win_cnt <= cfg.window;
      end else if (step && win_cnt != 8'h00) begin
        win_cnt <= win_cnt - 8'h01;
      end
    end
    assign double_hit = group_start && (win_cnt != 8'h00);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ch_oc[g] <= 1'b0;
      end else if (!ch_en[g]) begin
        ch_oc[g] <= 1'b0;
      end else if (single_hit || double_hit) begin
        ch_oc[g] <= 1'b1;
      end
    end
  end

  // pin drive: disabled pulls low with no pull-up, enabled releases
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_power_sense_pin_oe_n <= '0;
      port_pullup_en <= '0;
      shared_power_sense_pin_oe_n <= 1'b0;
      shared_pullup_en <= 1'b0;
    end else begin
      port_power_sense_pin_oe_n <= ch_en[N_PORTS-1:0];
      port_pullup_en <= ch_en[N_PORTS-1:0];
      shared_power_sense_pin_oe_n <= ch_en[N_PORTS];
      shared_pullup_en <= ch_en[N_PORTS];
    end
  end
  assign port_power_sense_pin_o = '0;
  assign shared_power_sense_pin_o = 1'b0;

  logic [N_PORTS-1:0] oc_flag;
  logic [N_PORTS-1:0] oc_prev;
  always_comb begin
    oc_flag = gang_mode ? {N_PORTS{ch_oc[N_PORTS]}} : ch_oc[N_PORTS-1:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_overcurrent <= '0;
      oc_prev <= '0;
    end else begin
      port_overcurrent <= oc_flag;
      oc_prev <= oc_flag;
    end
  end

  // write channel
  pod_wr_e wr_state;
  logic aw_held;
  logic w_held;
  pod_addr_t wr_addr;
  pod_data_t wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_hit;
  logic [13:0] wr_idx;

  assign s_axi_awready = (wr_state == POD_WR_COLLECT) && !aw_held;
  assign s_axi_wready = (wr_state == POD_WR_COLLECT) && !w_held;
  assign wr_fire = (wr_state == POD_WR_COLLECT) && aw_held && w_held;
  assign wr_idx = wr_addr[15:2];
  always_comb begin
    case (wr_idx)
      `POD_IDX_LOCKOUT, `POD_IDX_MIN_PULSE, `POD_IDX_WINDOW, `POD_IDX_CTRL,
      `POD_IDX_IRQ_STATUS, `POD_IDX_IRQ_MASK, `POD_IDX_PORT_STATE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state <= POD_WR_COLLECT;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      case (wr_state)
        POD_WR_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
          end
          if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            wr_state <= POD_WR_RESP;
          end
        end
        POD_WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state <= POD_WR_COLLECT;
          end
        end
        default: begin
          wr_state <= POD_WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // timing settings; zero writes are accepted as-is
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.lockout <= `POD_RST_LOCKOUT;
      cfg.min_width <= `POD_RST_MIN_PULSE;
      cfg.window <= `POD_RST_WINDOW;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_idx == `POD_IDX_LOCKOUT) cfg.lockout <= wr_data[7:0];
      if (wr_idx == `POD_IDX_MIN_PULSE) cfg.min_width <= wr_data[3:0];
      if (wr_idx == `POD_IDX_WINDOW) cfg.window <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_en <= '0;
      gang_mode <= 1'b0;
      irq_mask <= '0;
    end else if (wr_fire) begin
      if (wr_idx == `POD_IDX_CTRL && wr_strb[0]) port_en <= wr_data[N_PORTS-1:0];
      if (wr_idx == `POD_IDX_CTRL && wr_strb[1]) gang_mode <= wr_data[`POD_CTRL_GANG_BIT];
      if (wr_idx == `POD_IDX_IRQ_MASK && wr_strb[0]) irq_mask <= wr_data[N_PORTS-1:0];
    end
  end

  // new detection wins over a same-cycle write-one-to-clear
  logic [N_PORTS-1:0] irq_clr;
  assign irq_clr = (wr_fire && wr_idx == `POD_IDX_IRQ_STATUS && wr_strb[0]) ?
                   wr_data[N_PORTS-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | (oc_flag & ~oc_prev);
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read channel
  pod_rd_e rd_state;
  pod_data_t rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr[15:2])
      `POD_IDX_LOCKOUT: rd_word[7:0] = cfg.lockout;
      `POD_IDX_MIN_PULSE: rd_word[3:0] = cfg.min_width;
      `POD_IDX_WINDOW: rd_word[7:0] = cfg.window;
      `POD_IDX_CTRL: begin
        rd_word[N_PORTS-1:0] = port_en;
        rd_word[`POD_CTRL_GANG_BIT] = gang_mode;
      end
      `POD_IDX_IRQ_STATUS: rd_word[N_PORTS-1:0] = irq_status;
      `POD_IDX_IRQ_MASK: rd_word[N_PORTS-1:0] = irq_mask;
      `POD_IDX_PORT_STATE: begin
        rd_word[N_PORTS-1:0] = port_overcurrent;
        rd_word[`POD_STATE_PIN_LSB +: N_PORTS] = ch_sync[N_PORTS-1:0];
        rd_word[`POD_STATE_SHARED_BIT] = ch_sync[N_PORTS];
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = (rd_state == POD_RD_IDLE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state <= POD_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else begin
      case (rd_state)
        POD_RD_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
            rd_state <= POD_RD_RESP;
          end
        end
        POD_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= POD_RD_IDLE;
          end
        end
        default: begin
          rd_state <= POD_RD_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

endmodule : pod_top

// File: tb/pod_top_properties.sv
`timescale 1ns/1ps
module pod_checker #(
  parameter int N_PORTS = 7,
  parameter int MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire pod_pkg::pod_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pod_pkg::pod_data_t s_axi_rdata,
  input wire logic [N_PORTS-1:0] port_power_sense_pin_o,
  input wire logic shared_power_sense_pin_o,
  input wire logic [N_PORTS-1:0] port_power_sense_pin_oe_n,
  input wire logic [N_PORTS-1:0] port_pullup_en,
  input wire logic shared_power_sense_pin_oe_n,
  input wire logic shared_pullup_en,
  input wire logic [N_PORTS-1:0] port_overcurrent
);
  import pod_pkg::*;
  // default lockout less one step, since the step runs free
  localparam int LOCK_CYC = 9 * MS_CYCLES;
  logic [15:0] on_cnt;
  wire pwr0 = port_power_sense_pin_oe_n[0] | shared_power_sense_pin_oe_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) on_cnt <= 16'h0;
    else if (!pwr0) on_cnt <= 16'h0;
    else if (on_cnt != 16'hffff) on_cnt <= on_cnt + 16'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pullup_follows: assert property (port_pullup_en == port_power_sense_pin_oe_n)
    else $error("pull-up enable differs from driver release");
  a_shared_pullup: assert property (shared_pullup_en == shared_power_sense_pin_oe_n)
    else $error("shared pull-up differs from driver release");
  a_drive_low: assert property (port_power_sense_pin_o == '0)
    else $error("pin output value not low");
  a_shared_low: assert property (shared_power_sense_pin_o == 1'b0)
    else $error("shared pin output value not low");
  a_lockout_quiet: assert property ($rose(port_overcurrent[0]) |-> on_cnt >= LOCK_CYC)
    else $error("overcurrent flagged inside lockout");
  a_flag_clear: assert property ($fell(port_power_sense_pin_oe_n[0]) &&
    !shared_power_sense_pin_oe_n |-> ##[0:2] !port_overcurrent[0])
    else $error("flag not cleared at power off");
  a_flag_hold: assert property ($fell(port_overcurrent[0]) |-> !pwr0)
    else $error("flag dropped while powered");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn early");
  a_read_answer: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read data without address");
endmodule : pod_checker
bind pod_top pod_checker #(.N_PORTS(N_PORTS), .MS_CYCLES(MS_CYCLES)) u_chk (
  .clk, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_power_sense_pin_o, .shared_power_sense_pin_o,
  .port_power_sense_pin_oe_n, .port_pullup_en, .shared_power_sense_pin_oe_n,
  .shared_pullup_en, .port_overcurrent);

// File: tb/pod_switch.sv
`timescale 1ns/1ps
module pod_switch #(
  parameter int N = 7
) (
  input wire logic clk,
  input wire logic [N-1:0] o,
  input wire logic [N-1:0] oe_n,
  input wire logic [N-1:0] pullup_en,
  input wire logic [N-1:0] fault,
  output logic [N-1:0] pin
);
  logic tgl = 1'b0;
  // released line with no pull-up floats: toggle so no level is trusted
  always_ff @(posedge clk) tgl <= ~tgl;
  // switch pulls the open-drain line low on fault
  // poly-fuse board: power good counts as immediate, line valid at release
  assign pin = (~oe_n & o) | (oe_n & ~fault & (pullup_en | {N{tgl}}));
endmodule : pod_switch

// File: tb/pod_top_tb.sv
`timescale 1ns/1ps
`include "pod_params.svh"
module pod_top_tb;
  import pod_pkg::*;
  localparam pod_addr_t A_LOCK = {`POD_IDX_LOCKOUT, 2'b00};
  localparam pod_addr_t A_MIN = {`POD_IDX_MIN_PULSE, 2'b00};
  localparam pod_addr_t A_WIN = {`POD_IDX_WINDOW, 2'b00};
  localparam pod_addr_t A_CTRL = {`POD_IDX_CTRL, 2'b00};
  localparam pod_addr_t A_STAT = {`POD_IDX_IRQ_STATUS, 2'b00};
  localparam pod_addr_t A_MASK = {`POD_IDX_IRQ_MASK, 2'b00};
  localparam pod_addr_t A_STATE = {`POD_IDX_PORT_STATE, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, sfault = 1'b0;
  pod_addr_t awa = '0, ara = '0;
  pod_data_t wd = '0;
  logic [6:0] fault = '0;
  logic awr, wr_r, bv, arr, rv, irq, spin, so, soe_n, spu;
  pod_resp_t br, rr;
  pod_data_t rdat;
  logic [6:0] pin, po, oe_n, pu, oc;
  int n_errors = 0, cmp_count = 0;
  pod_top #(.MS_CYCLES(10)) u_dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .port_power_sense_pin_i(pin), .port_power_sense_pin_o(po),
    .port_power_sense_pin_oe_n(oe_n), .port_pullup_en(pu),
    .shared_power_sense_pin_i(spin), .shared_power_sense_pin_o(so),
    .shared_power_sense_pin_oe_n(soe_n), .shared_pullup_en(spu),
    .port_overcurrent(oc), .irq(irq));
  pod_switch u_sw (.clk(clk), .o(po), .oe_n(oe_n), .pullup_en(pu), .fault(fault), .pin(pin));
  // one switch on the shared line stands for all ports tied together
  pod_switch #(.N(1)) u_gang (.clk(clk), .o(so), .oe_n(soe_n), .pullup_en(spu),
    .fault(sfault), .pin(spin));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input pod_data_t got, input pod_data_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input pod_addr_t a, input pod_data_t d, input pod_resp_t er);
    logic ta, tw, tb;
    pod_resp_t r;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(negedge clk);
      ta = awr;
      tw = wr_r;
      tb = bv;
      r = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    brdy <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input pod_addr_t a, input pod_data_t ed, input pod_resp_t er);
    logic ta, tr;
    pod_data_t d;
    pod_resp_t r;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(negedge clk);
      ta = arr;
      tr = rv;
      d = rdat;
      r = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rrdy <= 1'b0;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(input int n);
    @(posedge clk);
    fault[0] <= 1'b1;
    repeat (n) @(posedge clk);
    fault[0] <= 1'b0;
  endtask : pulse
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk({25'h0, oe_n | pu}, 32'h0);
    rd(A_LOCK, 32'h0a, 2'b00);
    rd(A_MIN, 32'h05, 2'b00);
    rd(A_WIN, 32'h14, 2'b00);
    wr(16'hc000, 32'h1, 2'b10);
    rd(16'hc000, 32'h0, 2'b10);
    wr(A_MIN, 32'hff, 2'b00);
    rd(A_MIN, 32'h0f, 2'b00);
    wr(A_MIN, 32'h02, 2'b00);
    wr(A_WIN, 32'h03, 2'b00);
    fault[0] <= 1'b1;
    wr(A_CTRL, 32'h1, 2'b00);
    cyc(2);
    chk({25'h0, oe_n & pu}, 32'h1);
    cyc(75);
    chk({25'h0, oc}, 32'h0);
    cyc(70);
    chk({25'h0, oc}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(A_STAT, 32'h1, 2'b00);
    wr(A_MASK, 32'h1, 2'b00);
    cyc(1);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    fault[0] <= 1'b0;
    cyc(50);
    chk({25'h0, oc}, 32'h1);
    rd(A_STATE, 32'h101, 2'b00);
    wr(A_STAT, 32'h1, 2'b00);
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    rd(A_STAT, 32'h0, 2'b00);
    wr(A_CTRL, 32'h0, 2'b00);
    cyc(3);
    chk({25'h0, oc}, 32'h0);
    @(posedge clk);
    fault[0] <= 1'b1;
    wr(A_CTRL, 32'h1, 2'b00);
    cyc(80);
    chk({25'h0, oc}, 32'h0);
    @(posedge clk);
    fault[0] <= 1'b0;
    cyc(40);
    pulse(3);
    cyc(60);
    chk({25'h0, oc}, 32'h0);
    pulse(3);
    cyc(8);
    pulse(3);
    cyc(8);
    chk({25'h0, oc}, 32'h1);
    wr(A_CTRL, 32'h0, 2'b00);
    wr(A_CTRL, 32'h101, 2'b00);
    cyc(2);
    chk({24'h0, soe_n, oe_n}, 32'h80);
    cyc(110);
    @(posedge clk);
    sfault <= 1'b1;
    cyc(40);
    chk({25'h0, oc}, 32'h7f);
    rd(A_STATE, 32'h7f, 2'b00);
    give_verdict();
  end
endmodule : pod_top_tb
